// ===== rtl/ioie_pkg.sv
// Purpose: Shared constants for the input event, pulse metering and relay output block
// Assumes: 40 MHz clock, word-indexed register port
// Notes: Event codes of the second module sit one page above the first module's
`default_nettype none
package ioie_pkg;
    localparam int DIN_N = 6;
    localparam int DOUT_N = 3;
    localparam int REG_AW = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 32;
    localparam int WEIGHT_W = 24;
    localparam int TOTAL_W = 48;
    localparam int UNIT_W = 2;
    localparam int CODE_W = 16;

    // Counter limits and reset values
    localparam logic [CNT_W-1:0] CNT_MAX = 32'hFFFFFFFE;
    localparam logic [CNT_W-1:0] THR_RST = 32'h00001388;
    localparam logic [WEIGHT_W-1:0] WEIGHT_RST = 24'h000001;

    // Pulse unit encodings
    localparam logic [UNIT_W-1:0] UNIT_WH = 2'h0;
    localparam logic [UNIT_W-1:0] UNIT_VARH = 2'h1;
    localparam logic [UNIT_W-1:0] UNIT_VAH = 2'h2;
    localparam logic [UNIT_W-1:0] UNIT_M3 = 2'h3;
    localparam logic [UNIT_W-1:0] UNIT_RST = UNIT_WH;

    // Event codes, first module
    localparam logic [CODE_W-1:0] EVT_EDGE_BASE = 16'h0613;
    localparam logic [CODE_W-1:0] EVT_ALARM_BASE = 16'h0619;
    localparam logic [CODE_W-1:0] EVT_FORCE_BASE = 16'h0622;
    localparam logic [CODE_W-1:0] MODULE2_OFS = 16'h0100;

    // Global registers (word index)
    localparam logic [REG_AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [REG_AW-1:0] ADDR_STATUS = 8'h01;
    localparam logic [REG_AW-1:0] ADDR_SIGTYPE = 8'h02;
    localparam logic [REG_AW-1:0] ADDR_CONTACT = 8'h03;
    localparam logic [REG_AW-1:0] ADDR_POLARITY = 8'h04;
    localparam logic [REG_AW-1:0] ADDR_FORCE_EN = 8'h05;
    localparam logic [REG_AW-1:0] ADDR_FORCE_VAL = 8'h06;
    localparam logic [REG_AW-1:0] ADDR_ALARM = 8'h07;
    localparam logic [REG_AW-1:0] ADDR_CNT_CLR = 8'h08;
    localparam logic [REG_AW-1:0] ADDR_OUT_CMD = 8'h09;
    localparam logic [REG_AW-1:0] ADDR_OUT_LOCK = 8'h0A;
    localparam logic [REG_AW-1:0] ADDR_OUT_STATE = 8'h0B;
    localparam logic [REG_AW-1:0] ADDR_IN_LEVEL = 8'h0C;

    // Per-input banks: index = ADDR[7:4] - 1, field = ADDR[3:0]
    localparam logic [3:0] BANK_FIRST = 4'h1;
    localparam logic [3:0] BANK_LAST = 4'h6;
    localparam logic [3:0] F_COUNT = 4'h0;
    localparam logic [3:0] F_THRESH = 4'h1;
    localparam logic [3:0] F_UNIT = 4'h2;
    localparam logic [3:0] F_WEIGHT = 4'h3;
    localparam logic [3:0] F_TOTAL_LO = 4'h4;
    localparam logic [3:0] F_TOTAL_HI = 4'h5;

    // Status bits
    localparam int ST_INIT_DONE = 0;
    localparam int ST_REJECT = 1;

    // Timing
    localparam int CLK_HZ = 40000000;
    localparam int MIN_PULSE_MS = 40;
    localparam int COIL_TIME_MS = 10;
    localparam int COIL_CYC = COIL_TIME_MS * (CLK_HZ / 1000);
endpackage : ioie_pkg
`default_nettype wire

// ===== rtl/ioie_in_chan.sv
// Purpose: One digital input: sync, forcing, contact sense, counter, alarm, pulse total
// Assumes: Pin is asynchronous to clk
// Notes: Events are one-cycle pulses; alarm is sticky until cleared
`default_nettype none
module ioie_in_chan
    import ioie_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pin,
    input wire logic pulse_type,
    input wire logic brk,
    input wire logic pol,
    input wire logic force_en,
    input wire logic force_val,
    input wire logic [ioie_pkg::CNT_W-1:0] thr,
    input wire logic [ioie_pkg::WEIGHT_W-1:0] weight,
    input wire logic cnt_clr,
    input wire logic alarm_clr,
    output logic level,
    output logic ev_act,
    output logic ev_force,
    output logic ev_alarm,
    output logic alarm,
    output logic [ioie_pkg::CNT_W-1:0] count,
    output logic [ioie_pkg::TOTAL_W-1:0] total
);
    logic s1;
    logic s2;
    logic prev_level;
    logic prev_force;
    logic [1:0] armed;

    wire eff = force_en ? force_val : s2;
    wire active = eff ^ brk;
    wire prev_active = prev_level ^ brk;
    wire act_edge = armed[1] & active & ~prev_active;
    wire rise = armed[1] & eff & ~prev_level;
    wire fall = armed[1] & ~eff & prev_level;
    wire pulse_edge = pulse_type & (pol ? fall : rise);
    wire cnt_inc = pulse_type ? pulse_edge : act_edge;
    wire [CNT_W-1:0] cnt_plus = count + 32'h00000001;
    wire cnt_step = cnt_inc & (count != CNT_MAX);
    wire hit = cnt_step & (cnt_plus == thr) & ~cnt_clr;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            armed <= 2'h0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            armed <= {armed[0], 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_level <= 1'b0;
            prev_force <= 1'b0;
            level <= 1'b0;
            ev_act <= 1'b0;
            ev_force <= 1'b0;
            ev_alarm <= 1'b0;
        end else begin
            prev_level <= eff;
            prev_force <= force_en;
            level <= eff;
            ev_act <= act_edge;
            ev_force <= force_en ^ prev_force;
            ev_alarm <= hit;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || cnt_clr) begin
            count <= '0;
            total <= '0;
        end else begin
            if (cnt_step) begin
                count <= cnt_plus;
            end
            if (pulse_edge) begin
                total <= total + TOTAL_W'(weight);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alarm <= 1'b0;
        end else if (hit) begin
            alarm <= 1'b1;
        end else if (alarm_clr) begin
            alarm <= 1'b0;
        end
    end
endmodule : ioie_in_chan
`default_nettype wire

// ===== rtl/ioie_relay.sv
// Purpose: Bistable relay driver with open pulse at start-up
// Assumes: Relay latches after one coil pulse of COIL_CYC cycles
// Notes: Target changes are taken only when idle
`default_nettype none
module ioie_relay #(
    parameter int COIL_CYC = 400000
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic target,
    output logic open_coil,
    output logic close_coil,
    output logic closed,
    output logic settled
);
    typedef enum logic [1:0] {R_INIT, R_IDLE, R_OPENING, R_CLOSING} ioie_relay_t;
    ioie_relay_t state;
    logic [31:0] timer;

    wire done = (timer == 32'(COIL_CYC - 1));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= R_INIT;
            timer <= '0;
            open_coil <= 1'b0;
            close_coil <= 1'b0;
            closed <= 1'b0;
            settled <= 1'b0;
        end else begin
            case (state)
                R_INIT: begin
                    open_coil <= 1'b1;
                    state <= R_OPENING;
                end
                R_IDLE: begin
                    if (target != closed) begin
                        close_coil <= target;
                        open_coil <= ~target;
                        state <= target ? R_CLOSING : R_OPENING;
                    end
                end
                R_OPENING, R_CLOSING: begin
                    timer <= done ? '0 : timer + 32'h00000001;
                    if (done) begin
                        open_coil <= 1'b0;
                        close_coil <= 1'b0;
                        closed <= (state == R_CLOSING);
                        settled <= 1'b1;
                        state <= R_IDLE;
                    end
                end
                default: state <= R_INIT;
            endcase
        end
    end
endmodule : ioie_relay
`default_nettype wire

// ===== rtl/ioie_top.sv
// Purpose: Six digital inputs with events, counters, pulse metering; three relay outputs
// Assumes: Register port with one-cycle strobes, read data in the following cycle
// Notes: One event leaves per cycle; simultaneous events wait in pending bits
//
// Contract
// - Log an edge event per input on activation; codes consecutive, module-specific.
// - Counter threshold overrun raises a sticky medium alarm, cleared only by reset command.
// - Log an event whenever an input changes between forced and not forced.
// - Pulse counting is enabled only while input type is pulse.
// - Polarity chooses counting on rising or falling transition, rising by default.
// - Each pulse input holds a unit: Wh, VARh, VAh or cubic metres; Wh default.
// - Each pulse input holds a 24-bit weight, default one.
// - Each input has a normal or pulse type, normal by default.
// - Three digital outputs, each driving a bistable relay.
// - Locked outputs keep their preset and reject reconfiguration.
// - At every power-on all outputs are driven open before normal operation.
// - Each normal input counter increments on every activation edge.
// - Input counter saturates at its maximum count.
// - Threshold settable up to maximum, default 5000; alarm when counter reaches it.
// - Contact type make or break decides which input level is active.
`default_nettype none
module ioie_top
    import ioie_pkg::*;
#(
    parameter int COIL_CYCLES = ioie_pkg::COIL_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ioie_pkg::REG_AW-1:0] reg_addr,
    input wire logic [ioie_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ioie_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [ioie_pkg::DIN_N-1:0] din_pin,
    output logic [ioie_pkg::DOUT_N-1:0] relay_open_coil,
    output logic [ioie_pkg::DOUT_N-1:0] relay_close_coil,
    output logic event_valid,
    output logic [ioie_pkg::CODE_W-1:0] event_code,
    output logic event_is_alarm,
    output logic [ioie_pkg::DIN_N-1:0] alarm,
    output logic init_done
);
    import ioie_pkg::*;

    localparam int EV_N = 3 * DIN_N;

    // Configuration
    logic second_module;
    logic [DIN_N-1:0] sig_type;
    logic [DIN_N-1:0] contact_brk;
    logic [DIN_N-1:0] polarity;
    logic [DIN_N-1:0] force_en;
    logic [DIN_N-1:0] force_val;
    logic [DOUT_N-1:0] out_cmd;
    logic [DOUT_N-1:0] out_lock;
    logic reject;
    logic [CNT_W-1:0] thr [DIN_N];
    logic [WEIGHT_W-1:0] weight [DIN_N];
    logic [UNIT_W-1:0] unit [DIN_N];
    logic [EV_N-1:0] pending;

    // Channel and relay state
    logic [DIN_N-1:0] level;
    logic [DIN_N-1:0] ev_act;
    logic [DIN_N-1:0] ev_force;
    logic [DIN_N-1:0] ev_alarm;
    logic [CNT_W-1:0] count [DIN_N];
    logic [TOTAL_W-1:0] total [DIN_N];
    logic [DOUT_N-1:0] closed;
    logic [DOUT_N-1:0] settled;

    // Address decode
    wire [3:0] bank_sel = reg_addr[7:4];
    wire [3:0] field = reg_addr[3:0];
    wire in_bank = (bank_sel >= BANK_FIRST) && (bank_sel <= BANK_LAST);
    wire [2:0] bidx = 3'(bank_sel - BANK_FIRST);
    wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    wire wr_status = reg_wr && (reg_addr == ADDR_STATUS);
    wire wr_sigtype = reg_wr && (reg_addr == ADDR_SIGTYPE);
    wire wr_contact = reg_wr && (reg_addr == ADDR_CONTACT);
    wire wr_pol = reg_wr && (reg_addr == ADDR_POLARITY);
    wire wr_fen = reg_wr && (reg_addr == ADDR_FORCE_EN);
    wire wr_fval = reg_wr && (reg_addr == ADDR_FORCE_VAL);
    wire wr_alarm = reg_wr && (reg_addr == ADDR_ALARM);
    wire wr_cclr = reg_wr && (reg_addr == ADDR_CNT_CLR);
    wire wr_ocmd = reg_wr && (reg_addr == ADDR_OUT_CMD);
    wire wr_olock = reg_wr && (reg_addr == ADDR_OUT_LOCK);
    wire wr_bank = reg_wr && in_bank;
    wire [DIN_N-1:0] alarm_clr = wr_alarm ? reg_wdata[DIN_N-1:0] : '0;
    wire [DIN_N-1:0] cnt_clr = wr_cclr ? reg_wdata[DIN_N-1:0] : '0;
    wire [DOUT_N-1:0] new_cmd = reg_wdata[DOUT_N-1:0];
    wire lock_hit = wr_ocmd && (((new_cmd ^ out_cmd) & out_lock) != '0);
    wire [DOUT_N-1:0] next_out_cmd = (out_cmd & out_lock) | (new_cmd & ~out_lock);

    // Read mux
    wire [DATA_W-1:0] bank_word =
        (field == F_COUNT) ? count[bidx] :
        (field == F_THRESH) ? thr[bidx] :
        (field == F_UNIT) ? DATA_W'(unit[bidx]) :
        (field == F_WEIGHT) ? DATA_W'(weight[bidx]) :
        (field == F_TOTAL_LO) ? total[bidx][DATA_W-1:0] :
        (field == F_TOTAL_HI) ? DATA_W'(total[bidx][TOTAL_W-1:DATA_W]) : '0;
    wire [DATA_W-1:0] rd_word =
        (reg_addr == ADDR_CTRL) ? DATA_W'(second_module) :
        (reg_addr == ADDR_STATUS) ? DATA_W'({reject, init_done}) :
        (reg_addr == ADDR_SIGTYPE) ? DATA_W'(sig_type) :
        (reg_addr == ADDR_CONTACT) ? DATA_W'(contact_brk) :
        (reg_addr == ADDR_POLARITY) ? DATA_W'(polarity) :
        (reg_addr == ADDR_FORCE_EN) ? DATA_W'(force_en) :
        (reg_addr == ADDR_FORCE_VAL) ? DATA_W'(force_val) :
        (reg_addr == ADDR_ALARM) ? DATA_W'(alarm) :
        (reg_addr == ADDR_OUT_CMD) ? DATA_W'(out_cmd) :
        (reg_addr == ADDR_OUT_LOCK) ? DATA_W'(out_lock) :
        (reg_addr == ADDR_OUT_STATE) ? DATA_W'(closed) :
        (reg_addr == ADDR_IN_LEVEL) ? DATA_W'(level) :
        in_bank ? bank_word : '0;

    // Event selection: lowest pending bit leaves first
    function automatic logic [4:0] first_set(input logic [EV_N-1:0] v);
        logic [4:0] idx;
        idx = 5'h1F;
        for (int k = EV_N - 1; k >= 0; k--) begin
            if (v[k]) begin
                idx = 5'(k);
            end
        end
        return idx;
    endfunction : first_set

    wire [4:0] sel = first_set(pending);
    wire sel_valid = (pending != '0);
    wire [EV_N-1:0] grant = sel_valid ? (EV_N'(1) << sel) : '0;
    wire [EV_N-1:0] ev_set = {ev_force, ev_alarm, ev_act};
    wire sel_alarm = (sel >= 5'(DIN_N)) && (sel < 5'(2 * DIN_N));
    wire [CODE_W-1:0] base_code =
        (sel < 5'(DIN_N)) ? EVT_EDGE_BASE + CODE_W'(sel) :
        sel_alarm ? EVT_ALARM_BASE + CODE_W'(sel - 5'(DIN_N)) :
        EVT_FORCE_BASE + CODE_W'(sel - 5'(2 * DIN_N));
    wire [CODE_W-1:0] next_code = second_module ? base_code + MODULE2_OFS : base_code;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_word : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            second_module <= 1'b0;
            sig_type <= '0;
            contact_brk <= '0;
            polarity <= '0;
            force_en <= '0;
            force_val <= '0;
        end else begin
            if (wr_ctrl) second_module <= reg_wdata[0];
            if (wr_sigtype) sig_type <= reg_wdata[DIN_N-1:0];
            if (wr_contact) contact_brk <= reg_wdata[DIN_N-1:0];
            if (wr_pol) polarity <= reg_wdata[DIN_N-1:0];
            if (wr_fen) force_en <= reg_wdata[DIN_N-1:0];
            if (wr_fval) force_val <= reg_wdata[DIN_N-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_cmd <= '0;
            out_lock <= '0;
            reject <= 1'b0;
        end else begin
            if (wr_ocmd) out_cmd <= next_out_cmd;
            if (wr_olock) out_lock <= out_lock | reg_wdata[DOUT_N-1:0];
            if (lock_hit) begin
                reject <= 1'b1;
            end else if (wr_status && reg_wdata[ST_REJECT]) begin
                reject <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < DIN_N; i++) begin
            if (sys_rst) begin
                thr[i] <= THR_RST;
                weight[i] <= WEIGHT_RST;
                unit[i] <= UNIT_RST;
            end else if (wr_bank && (bidx == 3'(i))) begin
                if (field == F_THRESH && reg_wdata != '0 && reg_wdata <= CNT_MAX) begin
                    thr[i] <= reg_wdata;
                end
                if (field == F_WEIGHT) weight[i] <= reg_wdata[WEIGHT_W-1:0];
                if (field == F_UNIT) unit[i] <= reg_wdata[UNIT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pending <= '0;
            event_valid <= 1'b0;
            event_code <= '0;
            event_is_alarm <= 1'b0;
            init_done <= 1'b0;
        end else begin
            pending <= (pending & ~grant) | ev_set;
            event_valid <= sel_valid;
            event_code <= sel_valid ? next_code : '0;
            event_is_alarm <= sel_valid & sel_alarm;
            init_done <= &settled;
        end
    end

    for (genvar i = 0; i < DIN_N; i++) begin : g_in
        ioie_in_chan u_chan (
            .clk(clk),
            .sys_rst(sys_rst),
            .pin(din_pin[i]),
            .pulse_type(sig_type[i]),
            .brk(contact_brk[i]),
            .pol(polarity[i]),
            .force_en(force_en[i]),
            .force_val(force_val[i]),
            .thr(thr[i]),
            .weight(weight[i]),
            .cnt_clr(cnt_clr[i]),
            .alarm_clr(alarm_clr[i]),
            .level(level[i]),
            .ev_act(ev_act[i]),
            .ev_force(ev_force[i]),
            .ev_alarm(ev_alarm[i]),
            .alarm(alarm[i]),
            .count(count[i]),
            .total(total[i])
        );
    end

    for (genvar j = 0; j < DOUT_N; j++) begin : g_out
        ioie_relay #(
            .COIL_CYC(COIL_CYCLES)
        ) u_relay (
            .clk(clk),
            .sys_rst(sys_rst),
            .target(out_cmd[j]),
            .open_coil(relay_open_coil[j]),
            .close_coil(relay_close_coil[j]),
            .closed(closed[j]),
            .settled(settled[j])
        );
    end
endmodule : ioie_top
`default_nettype wire

// ===== testbench/ioie_contacts.sv
// Purpose: External contacts and pulse meter in front of the six inputs
// Assumes: Bench sets resting levels; one pulse at a time
// Notes: Pulse length is chosen per request so short and long pulses can be made
`default_nettype none
module ioie_contacts (
    input wire logic clk,
    input wire logic [5:0] rest_lvl,
    input wire logic go,
    input wire logic [2:0] idx,
    input wire logic [7:0] len,
    output logic [5:0] din_pin
);
    logic [7:0] left = 8'h00;
    logic [2:0] cur = 3'h0;
    always_ff @(posedge clk) begin
        if (go) begin
            left <= len;
            cur <= idx;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    // Pulse held for the full requested length
    assign din_pin = rest_lvl ^ ((left != 8'h00) ? (6'h01 << cur) : 6'h00);
endmodule : ioie_contacts
`default_nettype wire

// ===== testbench/ioie_top_assertions.sv
// Purpose: Port-level checks of events, register reads and relay coils
// Assumes: One clock, synchronous active-high reset
// Notes: Coil lengths are measured by helper counters
`default_nettype none
module ioie_chk
    import ioie_pkg::*;
#(
    parameter int COIL_CYCLES = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ioie_pkg::REG_AW-1:0] reg_addr,
    input wire logic [ioie_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ioie_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [ioie_pkg::DIN_N-1:0] din_pin,
    input wire logic [ioie_pkg::DOUT_N-1:0] relay_open_coil,
    input wire logic [ioie_pkg::DOUT_N-1:0] relay_close_coil,
    input wire logic event_valid,
    input wire logic [ioie_pkg::CODE_W-1:0] event_code,
    input wire logic event_is_alarm,
    input wire logic [ioie_pkg::DIN_N-1:0] alarm,
    input wire logic init_done
);
    int oc_len;
    int cc_len;
    wire logic [15:0] base_code = event_code & 16'hFEFF;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oc_len <= 0;
            cc_len <= 0;
        end else begin
            oc_len <= relay_open_coil[0] ? oc_len + 1 : 0;
            cc_len <= relay_close_coil[0] ? cc_len + 1 : 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_start_open;
        ##[0:2] (relay_open_coil == 3'h7);
    endsequence
    sequence s_init_low;
        !init_done [*8];
    endsequence
    property p_evt_range;
        event_valid |-> base_code inside {[16'h0613:16'h061E], [16'h0622:16'h0627]};
    endproperty
    a_evt_range: assert property (p_evt_range) else $error("event code out of range");
    property p_alarm_flag;
        event_valid |-> event_is_alarm == (base_code inside {[16'h0619:16'h061E]});
    endproperty
    a_alarm_flag: assert property (p_alarm_flag) else $error("alarm flag wrong");
    property p_evt_idle;
        !event_valid |-> !event_is_alarm && event_code == 16'h0000;
    endproperty
    a_evt_idle: assert property (p_evt_idle) else $error("code without event");
    property p_rdata_zero;
        !$past(reg_rd) |-> reg_rdata == 32'h00000000;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside slot");
    property p_start_open;
        $fell(sys_rst) |-> s_start_open;
    endproperty
    a_start_open: assert property (p_start_open) else $error("no open pulse at start");
    property p_init_low;
        $fell(sys_rst) |-> s_init_low;
    endproperty
    a_init_low: assert property (p_init_low) else $error("init done too early");
    property p_init_stays;
        init_done |=> init_done;
    endproperty
    a_init_stays: assert property (p_init_stays) else $error("init done dropped");
    property p_no_close_early;
        !init_done |-> relay_close_coil == 3'h0;
    endproperty
    a_no_close_early: assert property (p_no_close_early) else $error("close before init");
    property p_coil_excl;
        (relay_open_coil & relay_close_coil) == 3'h0;
    endproperty
    a_coil_excl: assert property (p_coil_excl) else $error("both coils driven");
    property p_alarm_sticky;
        !$past(sys_rst) && !$past(reg_wr && reg_addr == ADDR_ALARM)
            |-> (alarm & $past(alarm)) == $past(alarm);
    endproperty
    a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm lost");
    property p_open_len;
        $fell(relay_open_coil[0]) && !$past(sys_rst) |-> oc_len == COIL_CYCLES;
    endproperty
    a_open_len: assert property (p_open_len) else $error("open coil length");
    property p_close_len;
        $fell(relay_close_coil[0]) && !$past(sys_rst) |-> cc_len == COIL_CYCLES;
    endproperty
    a_close_len: assert property (p_close_len) else $error("close coil length");
endmodule : ioie_chk
bind ioie_top ioie_chk #(.COIL_CYCLES(COIL_CYCLES)) u_chk (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .din_pin(din_pin), .relay_open_coil(relay_open_coil),
    .relay_close_coil(relay_close_coil), .event_valid(event_valid),
    .event_code(event_code), .event_is_alarm(event_is_alarm), .alarm(alarm),
    .init_done(init_done));
`default_nettype wire

// ===== testbench/tb.sv
// Purpose: Self-checking bench for input events, pulse metering and relays
// Assumes: Coil pulse shortened to 8 cycles
// Notes: Events are queued by a monitor and compared in order
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ioie_pkg::*;
    logic clk, sys_rst, reg_wr, reg_rd, go, event_valid, event_is_alarm, init_done;
    logic [7:0] reg_addr, plen;
    logic [31:0] reg_wdata, reg_rdata;
    logic [5:0] din_pin, rest_lvl, alarm;
    logic [2:0] relay_open_coil, relay_close_coil, pidx;
    logic [15:0] event_code;
    logic [16:0] evq[$];
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    ioie_top #(.COIL_CYCLES(8)) dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .din_pin(din_pin), .relay_open_coil(relay_open_coil),
        .relay_close_coil(relay_close_coil), .event_valid(event_valid),
        .event_code(event_code), .event_is_alarm(event_is_alarm), .alarm(alarm),
        .init_done(init_done));
    ioie_contacts meter (.clk(clk), .rest_lvl(rest_lvl), .go(go), .idx(pidx), .len(plen),
        .din_pin(din_pin));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (event_valid === 1'b1) evq.push_back({event_is_alarm, event_code});
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk(reg_rdata, e);
    endtask : rdc
    task automatic ev(input logic [16:0] e);
        int n;
        logic [16:0] g;
        g = 17'h1FFFF;
        for (n = 0; n < 60 && evq.size() == 0; n++) @(posedge clk);
        if (evq.size() > 0) g = evq.pop_front();
        chk({15'h0, g}, {15'h0, e});
    endtask : ev
    task automatic lvl(input logic [5:0] v);
        @(posedge clk);
        rest_lvl <= v;
        repeat (10) @(posedge clk);
    endtask : lvl
    task automatic pulse(input logic [2:0] i, input logic [7:0] n);
        @(posedge clk);
        go <= 1'b1;
        pidx <= i;
        plen <= n;
        @(posedge clk);
        go <= 1'b0;
        repeat (n + 8) @(posedge clk);
    endtask : pulse
    task automatic t_reset;
        int n;
        repeat (3) @(posedge clk);
        chk({29'h0, relay_open_coil}, 32'h7);
        for (n = 0; n < 60 && init_done !== 1'b1; n++) @(posedge clk);
        rdc(ADDR_STATUS, 32'h1);
        rdc(ADDR_OUT_STATE, 32'h0);
        rdc(ADDR_SIGTYPE, 32'h0);
        rdc(ADDR_POLARITY, 32'h0);
        rdc(8'h11, THR_RST);
        rdc(8'h12, {30'h0, UNIT_RST});
        rdc(8'h13, {8'h0, WEIGHT_RST});
        rdc(8'hFF, 32'h0);
    endtask : t_reset
    task automatic t_contact;
        pulse(3'h0, 8'h04);
        ev(17'h00613);
        rdc(8'h10, 32'h1);
        wr(ADDR_CONTACT, 32'h2);
        rdc(8'h20, 32'h0);
        lvl(6'h02);
        lvl(6'h00);
        ev(17'h00614);
        rdc(8'h20, 32'h1);
    endtask : t_contact
    task automatic t_alarm;
        wr(8'h11, 32'h3);
        wr(8'h11, 32'h0);
        rdc(8'h11, 32'h3);
        pulse(3'h0, 8'h04);
        pulse(3'h0, 8'h04);
        ev(17'h00613);
        ev(17'h00613);
        ev(17'h10619);
        chk({26'h0, alarm}, 32'h1);
        pulse(3'h0, 8'h04);
        ev(17'h00613);
        rdc(ADDR_ALARM, 32'h1);
        wr(ADDR_ALARM, 32'h1);
        rdc(ADDR_ALARM, 32'h0);
        wr(ADDR_CNT_CLR, 32'h1);
        rdc(8'h10, 32'h0);
    endtask : t_alarm
    task automatic t_force;
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_FORCE_EN, 32'h4);
        ev(17'h00724);
        wr(ADDR_FORCE_EN, 32'h0);
        ev(17'h00724);
        wr(ADDR_CTRL, 32'h0);
    endtask : t_force
    task automatic t_pulse;
        int u;
        wr(ADDR_SIGTYPE, 32'h8); // Single pulse input on this module
        wr(ADDR_POLARITY, 32'h8);
        wr(8'h43, 32'h00FFFFFF);
        lvl(6'h08);
        ev(17'h00616);
        rdc(8'h40, 32'h0);
        lvl(6'h00);
        rdc(8'h40, 32'h1);
        pulse(3'h3, 8'h08);
        ev(17'h00616);
        rdc(8'h44, 32'h01FFFFFE);
        rdc(8'h45, 32'h0);
        rdc(8'h14, 32'h0);
        for (u = 0; u < 4; u++) begin
            wr(8'h42, 32'(u));
            rdc(8'h42, 32'(u));
        end
    endtask : t_pulse
    task automatic t_relay;
        wr(ADDR_OUT_LOCK, 32'h4);
        wr(ADDR_OUT_CMD, 32'h7);
        rdc(ADDR_STATUS, 32'h3);
        repeat (30) @(posedge clk);
        rdc(ADDR_OUT_STATE, 32'h3);
        wr(ADDR_OUT_CMD, 32'h0);
        repeat (30) @(posedge clk);
        rdc(ADDR_OUT_STATE, 32'h0);
    endtask : t_relay
    initial begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rest_lvl = 6'h00;
        go = 1'b0;
        pidx = 3'h0;
        plen = 8'h00;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_contact();
        t_alarm();
        t_force();
        t_pulse();
        t_relay();
        chk(32'(evq.size()), 32'h0);
        test_done();
    end
endmodule : tb
`default_nettype wire
